// ---- tb/hc_props.sv ----
// Port assertions for the sequencer, status port and mux outputs.
// Assumes a bind onto the design top.
`timescale 1ns/1ps
module hc_props (
    input wire clk, rst, flash_owned_by_device, host_ctrl_rst_l, addr_valid, addr_ack, host_irq_l, display_mode,
    input wire cable_attached, status_read_done, sideband_select_a, sideband_select_b, aux_path_enable,
    input wire [6:0] addr_byte
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence up_s; $rose(cable_attached) ##0 cable_attached[*6]; endsequence
    ack_addr_a: assert property (addr_ack == $past(addr_valid && addr_byte == 7'h38)) else $error("ack");
    flash_first_a: assert property (host_ctrl_rst_l |-> !flash_owned_by_device) else $error("own");
    rst_hold_a: assert property (host_ctrl_rst_l |=> host_ctrl_rst_l) else $error("rst");
    irq_up_a: assert property (up_s |-> !host_irq_l) else $error("irq");
    irq_clr_a: assert property (status_read_done && $past(cable_attached, 3) |=> host_irq_l)
        else $error("clr");
    sel_pair_a: assert property (sideband_select_a == sideband_select_b) else $error("sel");
    aux_mode_a: assert property (aux_path_enable |-> $past(display_mode)) else $error("aux");
    off_idle_a: assert property (!cable_attached[*5] |-> !(sideband_select_a | aux_path_enable))
        else $error("off");
endmodule // hc_props
bind host_ctrl_reset_and_sideband hc_props props (.*);

// ---- tb/host_model.sv ----
// Host controller model: reads status while its interrupt is low.
// Assumes the design port names and one clock.
`timescale 1ns/1ps
module host_model #(
    // Supply settle time before reset may release: 100 us at 40 ns
    parameter SUPPLY_SETTLE_CYCLES = 2500
) (
    input wire clk, host_irq_l, host_ctrl_rst_l, addr_ack, wrong,
    output reg addr_valid = 1'b0, status_read_done = 1'b0, host_running = 1'b0,
    output reg [6:0] addr_byte = 7'h00
);
    reg [2:0] n = 3'h0;
    // Host supply is up from power-on; its reset is gated by the settled supply
    reg [11:0] settle = 12'h000;
    always @(posedge clk) begin
        if (settle != SUPPLY_SETTLE_CYCLES) settle <= settle + 12'h001;
        host_running <= host_ctrl_rst_l && settle == SUPPLY_SETTLE_CYCLES;
        n <= (!host_irq_l && host_running) ? n + 3'h1 : 3'h0;
        addr_valid <= n == 3'h2;
        addr_byte <= n != 3'h2 ? ~addr_byte : wrong ? 7'h39 : 7'h38;
        status_read_done <= addr_ack;
    end
endmodule // host_model

// ---- tb/tb_top.sv ----
// Random bench for the reset and sideband block.
// Assumes the design, its checker bind and the host model.
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin errors++; $display("CHECK FAILED %s %h %h", n, e, a); end end
module tb_top;
    bit clk, cfg_load_done, hold_until_boot, system_booted, wrong, cable_attached, cable_flipped, display_mode;
    bit host_link_mode, rst = 1;
    bit [7:0] data_status;
    wire cfg_load_start, flash_owned_by_device, host_ctrl_rst_l, addr_valid, addr_ack, host_irq_l, status_read_done;
    wire sideband_select_a, sideband_select_b, aux_path_enable, lowspeed_path_enable, host_running;
    wire [6:0] addr_byte;
    wire [7:0] read_data;
    wire [3:0] mux = {sideband_select_a, sideband_select_b, aux_path_enable, lowspeed_path_enable};
    integer errors = 0, cmp_count = 0, cyc = 0, seed = 20154, r;
    function [3:0] ex(input [3:0] p); ex = {p[2], p[2:0]} & {4{p[3]}}; endfunction
    host_model host (.*);
    host_ctrl_reset_and_sideband dut (.*);
    task finish_test;
        if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (++cyc > 6000) begin errors++; finish_test; end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        repeat (2) @(negedge clk);
        `CHK("start", 1'b1, cfg_load_start)
        @(negedge clk);
        `CHK("start end", 1'b0, cfg_load_start)
        @(negedge clk);
        `CHK("hold", 2'b10, {flash_owned_by_device, host_ctrl_rst_l})
        @(posedge clk) cfg_load_done <= 1;
        @(posedge clk) cfg_load_done <= 0;
        repeat (2) @(negedge clk);
        `CHK("run", 2'b01, {flash_owned_by_device, host_ctrl_rst_l})
        `CHK("gate", 1'b0, host_running)
        wait (host_running);
        repeat (300) begin
            @(posedge clk) r = $random(seed);
            {cable_attached, cable_flipped, display_mode, host_link_mode, data_status, wrong} <= r[12:0];
            repeat (6) @(negedge clk);
            `CHK("mux", ex(r[12:9]), mux)
            `CHK("read", r[8:1], read_data)
        end
        @(posedge clk) rst <= 1;
        hold_until_boot <= 1;
        cable_attached <= 0;
        repeat (3) @(negedge clk);
        `CHK("reset", 6'h10, {host_ctrl_rst_l, host_irq_l, mux})
        @(posedge clk) rst <= 0;
        @(posedge clk) cfg_load_done <= 1;
        @(posedge clk) cfg_load_done <= 0;
        repeat (8) @(negedge clk);
        `CHK("boot wait", 2'b00, {flash_owned_by_device, host_ctrl_rst_l})
        @(posedge clk) system_booted <= 1;
        repeat (4) @(negedge clk);
        `CHK("booted", 2'b01, {flash_owned_by_device, host_ctrl_rst_l})
        finish_test;
    end
endmodule // tb_top

// ---- verilog/host_ctrl_consts.vh ----
// Constants for the host controller reset and sideband block.
// Assumes inclusion by bare name from the design file.
`ifndef HOST_CTRL_CONSTS_VH
`define HOST_CTRL_CONSTS_VH

// Target address of the second I2C port
`define TARGET_I2C_ADDR 7'h38
// Bit positions of the pin inputs in the synchroniser
`define SYNC_WIDTH 5
`define SYNC_LINK 0
`define SYNC_FLIP 1
`define SYNC_ATTACH 2
`define SYNC_HOLD 3
`define SYNC_BOOTED 4

`endif

// ---- verilog/host_ctrl_reset_and_sideband.v ----
// Reset sequencing, target I2C status port and sideband mux control levels for a host data controller.
// Assumes a configuration loader that reports busy/done, an I2C target core upstream, one 25 MHz clock.
//
// Function
// - Device reads its flash configuration before the host controller may fetch firmware.
// - Host controller held in reset via dedicated output until configuration loaded and, when hold is requested, until the system has booted.
// - Second I2C port is a target answering address 0x38.
// - On connection, interrupt host; host then reads data status over I2C.
// - Orientation output drives both channel selects of sideband mux.
// - Display mode enables aux path; host link mode enables low-speed path.
`timescale 1ns/1ps
`include "host_ctrl_consts.vh"

module host_ctrl_reset_and_sideband #(
    parameter STATUS_WIDTH = 8
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Configuration load from shared flash
    input wire cfg_load_done,
    output reg cfg_load_start,
    output reg flash_owned_by_device,
    // Host controller reset and boot gating
    input wire hold_until_boot,
    input wire system_booted,
    output reg host_ctrl_rst_l,
    // Second target I2C port, address phase and read data
    input wire addr_valid,
    input wire [6:0] addr_byte,
    input wire [STATUS_WIDTH-1:0] data_status,
    output reg addr_ack,
    output reg [STATUS_WIDTH-1:0] read_data,
    output reg host_irq_l,
    // Connection and mode inputs
    input wire cable_attached,
    input wire cable_flipped,
    input wire display_mode,
    input wire host_link_mode,
    input wire status_read_done,
    // Sideband multiplexer controls
    output reg sideband_select_a,
    output reg sideband_select_b,
    output reg aux_path_enable,
    output reg lowspeed_path_enable
);

    // Sequencer state codes
    localparam [1:0] SEQ_IDLE = 2'h0;
    localparam [1:0] SEQ_LOAD = 2'h1;
    localparam [1:0] SEQ_HOLD = 2'h2;
    localparam [1:0] SEQ_RUN = 2'h3;

    // Sequencer state
    reg [1:0] state;
    reg [1:0] next_state;

    // Pin inputs and their synchronised copies
    wire [`SYNC_WIDTH-1:0] pin_raw;
    wire [`SYNC_WIDTH-1:0] sync;
    wire attached;
    wire flipped;
    wire link_mode;
    wire hold_req;
    wire booted;

    // Derived conditions
    reg attached_prev;
    wire attach_rise;
    wire boot_gate_open;

    // Next values of the registered outputs
    reg next_cfg_load_start;
    reg next_flash_owned;
    reg next_host_ctrl_rst_l;
    reg next_addr_ack;
    reg [STATUS_WIDTH-1:0] next_read_data;
    reg next_host_irq_l;
    reg next_select;
    reg next_aux_path_enable;
    reg next_lowspeed_path_enable;

    // Pins gathered in synchroniser order
    assign pin_raw[`SYNC_LINK] = host_link_mode;
    assign pin_raw[`SYNC_FLIP] = cable_flipped;
    assign pin_raw[`SYNC_ATTACH] = cable_attached;
    assign pin_raw[`SYNC_HOLD] = hold_until_boot;
    assign pin_raw[`SYNC_BOOTED] = system_booted;

    // Two flip-flops per pin; only the second stage is read
    genvar i;
    generate
        for (i = 0; i < `SYNC_WIDTH; i = i + 1) begin : pin_sync
            reg meta;
            reg stage;
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta <= 1'b0;
                    stage <= 1'b0;
                end else begin
                    meta <= pin_raw[i];
                    stage <= meta;
                end
            end
            assign sync[i] = stage;
        end
    endgenerate

    // Named views of the synchronised pins
    assign attached = sync[`SYNC_ATTACH];
    assign flipped = sync[`SYNC_FLIP];
    assign link_mode = sync[`SYNC_LINK];
    assign hold_req = sync[`SYNC_HOLD];
    assign booted = sync[`SYNC_BOOTED];

    // Release waits for the boot handshake only when hold is requested
    assign boot_gate_open = !hold_req || booted;
    assign attach_rise = attached && !attached_prev;

    // Next state: load once per reset, then wait for the boot gate
    always @* begin
        next_state = state;
        case (state)
            SEQ_IDLE: begin
                next_state = SEQ_LOAD;
            end
            SEQ_LOAD: begin
                if (cfg_load_done)
                    next_state = SEQ_HOLD;
            end
            SEQ_HOLD: begin
                if (boot_gate_open)
                    next_state = SEQ_RUN;
            end
            SEQ_RUN: begin
                next_state = SEQ_RUN;
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
    end

    // Sequencer outputs: load start decoded from the current state, flash ownership and reset from the state being entered
    always @* begin
        next_cfg_load_start = (state == SEQ_IDLE);
        // Device keeps the flash until its load completes
        next_flash_owned = (next_state == SEQ_IDLE) || (next_state == SEQ_LOAD);
        // Host controller stays in reset until the sequencer runs
        next_host_ctrl_rst_l = (next_state == SEQ_RUN);
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= SEQ_IDLE;
            cfg_load_start <= 1'b0;
            flash_owned_by_device <= 1'b1;
            host_ctrl_rst_l <= 1'b0;
        end else begin
            state <= next_state;
            cfg_load_start <= next_cfg_load_start;
            flash_owned_by_device <= next_flash_owned;
            host_ctrl_rst_l <= next_host_ctrl_rst_l;
        end
    end

    // Target port: ack only own address, return current status
    always @* begin
        next_addr_ack = addr_valid && (addr_byte == `TARGET_I2C_ADDR);
        next_read_data = data_status;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ack <= 1'b0;
            read_data <= {STATUS_WIDTH{1'b0}};
        end else begin
            addr_ack <= next_addr_ack;
            read_data <= next_read_data;
        end
    end

    // Interrupt on attach, held until the host reads status or the cable detaches; a new attach wins over a clear
    always @* begin
        next_host_irq_l = host_irq_l;
        if (attach_rise)
            next_host_irq_l = 1'b0;
        else if (status_read_done || !attached)
            next_host_irq_l = 1'b1;
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            attached_prev <= 1'b0;
            host_irq_l <= 1'b1;
        end else begin
            attached_prev <= attached;
            host_irq_l <= next_host_irq_l;
        end
    end

    // Mux controls as steady levels, all cleared on detach
    always @* begin
        next_select = attached && flipped;
        next_aux_path_enable = attached && display_mode;
        next_lowspeed_path_enable = attached && link_mode;
    end

    // Both channel selects follow one orientation decision
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sideband_select_a <= 1'b0;
            sideband_select_b <= 1'b0;
        end else begin
            sideband_select_a <= next_select;
            sideband_select_b <= next_select;
        end
    end

    // Path enables, one per mode
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            aux_path_enable <= 1'b0;
            lowspeed_path_enable <= 1'b0;
        end else begin
            aux_path_enable <= next_aux_path_enable;
            lowspeed_path_enable <= next_lowspeed_path_enable;
        end
    end

endmodule // host_ctrl_reset_and_sideband
